// [verilog/uwr_pkg.sv]
// Constants, types and helpers shared by the serial transceiver files
package uwr_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] BAUD_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] IRQF_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] CHAR_OFS = 8'h10;
  localparam logic [7:0] CLR_OFS = 8'h14;
  localparam logic [7:0] WAKE_OFS = 8'h18;
  localparam logic [7:0] ROUTE_OFS = 8'h40;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BAUD_W = 13;
  localparam int CTRL_W = 8;
  localparam int IRQF_W = 3;
  localparam int ROUTE_W = 14;
  localparam int STAT_T8_BIT = 5;
  localparam int STAT_R8_BIT = 6;
  localparam int WAKE_EN_BIT = 0;
  localparam int WAKE_FLAG_BIT = 1;
  localparam int WAKE_CLR_BIT = 2;
  localparam int ROUTE_SEL0_BIT = 5;
  localparam int ROUTE_SEL_BASE = 6;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 13'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [IRQF_W-1:0] IRQF_RESET = 3'h0;
  localparam logic [ROUTE_W-1:0] ROUTE_RESET = 14'h0000;
  localparam logic [7:0] CHAR_RESET = 8'hFF;
  // ****************************************
  // Timing
  // ****************************************
  localparam logic [3:0] RT_LAST = 4'hF;
  localparam logic [3:0] RT8 = 4'h7;
  localparam logic [3:0] RT9 = 4'h8;
  localparam logic [3:0] RT10 = 4'h9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_OFF_NS = 500;
  localparam int UNIT_OFF_CYCLES = (UNIT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic unitOn;
    logic txSideOn;
    logic rxSideOn;
    logic multiProc;
    logic twoStop;
    logic nineBit;
    logic parityCheckOn;
    logic parityOddSel;
  } uwr_frame_ctrl_s;
  typedef struct packed {
    logic txIrqGate;
    logic rxIrqGate;
    logic rxGlitchFilterOn;
  } uwr_irq_ctrl_s;
  typedef struct packed {
    logic txEmptyFlag;
    logic rxFullFlag;
    logic rxOverrunFlag;
    logic framingFaultFlag;
    logic parityFaultFlag;
  } uwr_flags_s;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_NINTH = 3'h2, TX_STOP = 3'h6, TX_STOP2 = 3'h7
  } uwr_tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_NINTH = 3'h2, RX_STOP = 3'h6
  } uwr_rx_state_e;
  // Parity bit for a byte: odd makes total ones odd
  function automatic logic parity_bit(input logic [7:0] data, input logic odd);
    parity_bit = (^data) ^ odd;
  endfunction : parity_bit
endpackage : uwr_pkg

// [verilog/uwr_baud_gen.sv]
// Sixteen-times bit-rate tick divider
module uwr_baud_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic restart,
  input wire logic [uwr_pkg::BAUD_W-1:0] divisor,
  output logic tick16
);
  // ****************************************
  // Divider
  // ****************************************
  logic [uwr_pkg::BAUD_W-1:0] cnt_reg;
  wire logic atEnd = (cnt_reg >= divisor - 13'h0001);
  wire logic running = (divisor != 13'h0000);

  // Count to divisor-1, pulse, wrap; a zero divisor stops the clock
  always_ff @(posedge sys_clk) begin
    if (!resetn || restart || !running) begin
      cnt_reg <= 13'h0000;
      tick16 <= 1'b0;
    end else begin
      cnt_reg <= atEnd ? 13'h0000 : cnt_reg + 13'h0001;
      tick16 <= atEnd;
    end
  end
endmodule : uwr_baud_gen

// [verilog/uwr_rx_filter.sv]
// Receive pin synchroniser and optional glitch filter
module uwr_rx_filter (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rawIn,
  input wire logic filterOn,
  output logic rxOut
);
  // ****************************************
  // Synchroniser and history
  // ****************************************
  logic syncA_reg;
  logic syncB_reg;
  logic [1:0] hist_reg;
  wire logic steady = (hist_reg == {2{syncB_reg}});

  // Two flops, then a short history of settled samples
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
      hist_reg <= 2'h3;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
      hist_reg <= {hist_reg[0], syncB_reg};
    end
  end

  // Filter passes a level only after three equal samples
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxOut <= 1'b1;
    end else if (!filterOn || steady) begin
      rxOut <= syncB_reg;
    end
  end
endmodule : uwr_rx_filter

// [verilog/uwr_top.sv]
// Serial transceiver with register bank, pin-pair routing and swap
//Behaviour
// - 13-bit baud divisor sets bit timing
// - Unit off clears state; 0.5us before re-enable
// - Bits 6/5 switch transmitter/receiver
// - Bit 4 selects address-filter mode
// - Bit 3 selects two stop bits
// - Bit 2 selects 9-bit characters
// - Ninth bit: parity or software value
// - Bit 0 selects odd parity
// - Gates mask irq; flags still set
// - Filter on receive pin when enabled
// - Status bit 6 shows received ninth
// - Ninth transmit bit locked under 9-bit parity
// - Status flags at bits 4 to 0
// - Data register: rx read, tx write
// - Write one clears matching flag
// - Wake enable, flag and clear bits
// - Pin pair select per instance
// - Swap bit exchanges transmit and receive
// - Data write starts frame; empty after stop
// - Full when char completes gives overrun
// - 16x sampling, majority at RT8-RT10
// - 9-bit address mode accepts ninth bit one only
//
// Implementation choice: the strobed register port.
module uwr_top #(
  parameter int INSTANCE = 0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic [3:0] pinAIn,
  input wire logic [3:0] pinBIn,
  output logic [3:0] pinAOut,
  output logic [3:0] pinAOe,
  output logic [3:0] pinBOut,
  output logic [3:0] pinBOe,
  output logic irqOut,
  output logic wakeOut
);
  // ****************************************
  // Software registers
  // ****************************************
  logic [uwr_pkg::BAUD_W-1:0] baudDivisor_reg;
  uwr_pkg::uwr_frame_ctrl_s ctrl_reg;
  uwr_pkg::uwr_irq_ctrl_s irqCtrl_reg;
  uwr_pkg::uwr_flags_s flags_reg;
  uwr_pkg::uwr_flags_s flags_next;
  logic [uwr_pkg::ROUTE_W-1:0] pinRoute_reg;
  logic txNinthBit_reg;
  logic rxNinthBit_reg;
  logic [7:0] rxBuf_reg;
  logic sleepWakeOn_reg;
  logic holdActive_reg;
  logic [6:0] holdCnt_reg;

  // Write strobe decode
  wire logic wrBaud = regWrEn && (regAddr == uwr_pkg::BAUD_OFS);
  wire logic wrCtrl = regWrEn && (regAddr == uwr_pkg::CTRL_OFS);
  wire logic wrIrqf = regWrEn && (regAddr == uwr_pkg::IRQF_OFS);
  wire logic wrStat = regWrEn && (regAddr == uwr_pkg::STAT_OFS);
  wire logic wrChar = regWrEn && (regAddr == uwr_pkg::CHAR_OFS);
  wire logic wrClr = regWrEn && (regAddr == uwr_pkg::CLR_OFS);
  wire logic wrWake = regWrEn && (regAddr == uwr_pkg::WAKE_OFS);
  wire logic wrRoute = regWrEn && (regAddr == uwr_pkg::ROUTE_OFS);

  // ****************************************
  // Unit enable and quiet time
  // ****************************************
  // Internal state held clear while off and for the quiet time after
  wire logic engineClr = !ctrl_reg.unitOn || holdActive_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      holdCnt_reg <= 7'h00;
      holdActive_reg <= 1'b0;
    end else if (!ctrl_reg.unitOn) begin
      holdCnt_reg <= 7'(uwr_pkg::UNIT_OFF_CYCLES - 1);
      holdActive_reg <= 1'b1;
    end else begin
      holdCnt_reg <= (holdCnt_reg != 7'h00) ? holdCnt_reg - 7'h01 : 7'h00;
      holdActive_reg <= (holdCnt_reg != 7'h00);
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      baudDivisor_reg <= uwr_pkg::BAUD_RESET;
      ctrl_reg <= uwr_pkg::CTRL_RESET;
      irqCtrl_reg <= uwr_pkg::IRQF_RESET;
      pinRoute_reg <= uwr_pkg::ROUTE_RESET;
      sleepWakeOn_reg <= 1'b0;
    end else begin
      if (wrBaud) baudDivisor_reg <= regWrData[uwr_pkg::BAUD_W-1:0];
      if (wrCtrl) ctrl_reg <= regWrData[uwr_pkg::CTRL_W-1:0];
      if (wrIrqf) irqCtrl_reg <= regWrData[uwr_pkg::IRQF_W-1:0];
      if (wrRoute) pinRoute_reg <= regWrData[uwr_pkg::ROUTE_W-1:0];
      if (wrWake) sleepWakeOn_reg <= regWrData[uwr_pkg::WAKE_EN_BIT];
    end
  end

  // Ninth transmit bit, locked while parity owns the ninth slot
  wire logic t8Locked = ctrl_reg.nineBit && ctrl_reg.parityCheckOn;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      txNinthBit_reg <= 1'b0;
    end else if (wrStat && !t8Locked) begin
      txNinthBit_reg <= regWrData[uwr_pkg::STAT_T8_BIT];
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  // Pair select field of this instance
  function automatic logic [1:0] pair_select(input logic [uwr_pkg::ROUTE_W-1:0] route);
    if (INSTANCE == 0) pair_select = {1'b0, route[uwr_pkg::ROUTE_SEL0_BIT]};
    else pair_select = route[uwr_pkg::ROUTE_SEL_BASE + 2 * (INSTANCE - 1) +: 2];
  endfunction : pair_select

  wire logic [1:0] pinPairSelect = pair_select(pinRoute_reg);
  wire logic pinSwap = pinRoute_reg[INSTANCE];
  wire logic rawRx = pinSwap ? pinAIn[pinPairSelect] : pinBIn[pinPairSelect];

  // ****************************************
  // Bit clock and receive input
  // ****************************************
  logic tick16;
  logic rxIn;

  uwr_baud_gen u_baud (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .restart(engineClr || wrBaud),
    .divisor(baudDivisor_reg),
    .tick16(tick16)
  );

  uwr_rx_filter u_filt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rawIn(rawRx),
    .filterOn(irqCtrl_reg.rxGlitchFilterOn),
    .rxOut(rxIn)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  uwr_pkg::uwr_tx_state_e txState_reg;
  uwr_pkg::uwr_tx_state_e txState_next;
  logic [7:0] txShift_reg;
  logic txNinthVal_reg;
  logic [3:0] txSub_reg;
  logic [2:0] txBit_reg;
  logic txLine_reg;

  wire logic txAbort = engineClr || !ctrl_reg.txSideOn;
  wire logic txStart = wrChar && (txState_reg == uwr_pkg::TX_IDLE) && !txAbort;
  wire logic txBitEnd = tick16 && (txSub_reg == uwr_pkg::RT_LAST);
  wire logic txDone = txBitEnd && (((txState_reg == uwr_pkg::TX_STOP) && !ctrl_reg.twoStop) ||
                                   (txState_reg == uwr_pkg::TX_STOP2));
  wire logic txParity = uwr_pkg::parity_bit(regWrData[7:0], ctrl_reg.parityOddSel);
  wire logic txNinthLoad = ctrl_reg.parityCheckOn ? txParity : txNinthBit_reg;
  wire logic txLine_next = (txState_reg == uwr_pkg::TX_START) ? 1'b0 :
                           (txState_reg == uwr_pkg::TX_DATA) ? txShift_reg[0] :
                           (txState_reg == uwr_pkg::TX_NINTH) ? txNinthVal_reg : 1'b1;

  // Next state of the transmit sequence
  always_comb begin
    txState_next = txState_reg;
    case (txState_reg)
      uwr_pkg::TX_IDLE: if (txStart) txState_next = uwr_pkg::TX_START;
      uwr_pkg::TX_START: if (txBitEnd) txState_next = uwr_pkg::TX_DATA;
      uwr_pkg::TX_DATA: begin
        if (txBitEnd && txBit_reg == 3'h7) begin
          txState_next = ctrl_reg.nineBit ? uwr_pkg::TX_NINTH : uwr_pkg::TX_STOP;
        end
      end
      uwr_pkg::TX_NINTH: if (txBitEnd) txState_next = uwr_pkg::TX_STOP;
      uwr_pkg::TX_STOP: if (txBitEnd) txState_next = ctrl_reg.twoStop ? uwr_pkg::TX_STOP2 : uwr_pkg::TX_IDLE;
      uwr_pkg::TX_STOP2: if (txBitEnd) txState_next = uwr_pkg::TX_IDLE;
      default: txState_next = uwr_pkg::TX_IDLE;
    endcase
  end

  // Transmit registers; the buffer is locked while a frame runs
  always_ff @(posedge sys_clk) begin
    if (!resetn || txAbort) begin
      txState_reg <= uwr_pkg::TX_IDLE;
      txShift_reg <= 8'h00;
      txNinthVal_reg <= 1'b0;
      txSub_reg <= 4'h0;
      txBit_reg <= 3'h0;
    end else begin
      txState_reg <= txState_next;
      if (txStart) begin
        txShift_reg <= regWrData[7:0];
        txNinthVal_reg <= txNinthLoad;
        txSub_reg <= 4'h0;
        txBit_reg <= 3'h0;
      end else if (tick16) begin
        txSub_reg <= txSub_reg + 4'h1;
        if (txBitEnd && txState_reg == uwr_pkg::TX_DATA) begin
          txShift_reg <= {1'b0, txShift_reg[7:1]};
          txBit_reg <= txBit_reg + 3'h1;
        end
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  uwr_pkg::uwr_rx_state_e rxState_reg;
  uwr_pkg::uwr_rx_state_e rxState_next;
  logic [3:0] rxSub_reg;
  logic [3:0] rxBit_reg;
  logic [7:0] rxShift_reg;
  logic rxNinthVal_reg;
  logic [1:0] rxVote_reg;
  logic [2:0] rxEdge_reg;

  wire logic rxAbort = engineClr || !ctrl_reg.rxSideOn;
  wire logic [3:0] rxSubInc = rxSub_reg + 4'h1;
  wire logic fallEdge = tick16 && (rxEdge_reg == 3'h7) && !rxIn;
  wire logic rxDecide = tick16 && !fallEdge && (rxSubInc == uwr_pkg::RT10);
  wire logic rxVote = (rxVote_reg[1] & rxVote_reg[0]) | (rxVote_reg[1] & rxIn) |
                      (rxVote_reg[0] & rxIn);
  wire logic rxBitEnd = tick16 && (fallEdge ? rxSub_reg[3] : (rxSub_reg == uwr_pkg::RT_LAST));
  wire logic rxEnd = rxDecide && (rxState_reg == uwr_pkg::RX_STOP);
  wire logic rxExpParity = uwr_pkg::parity_bit(rxShift_reg, ctrl_reg.parityOddSel);
  wire logic rxAccept = rxEnd && !(ctrl_reg.multiProc && ctrl_reg.nineBit && !rxNinthVal_reg);
  wire logic rxLoad = rxAccept && !flags_reg.rxFullFlag;

  // Next state of the receive sequence
  always_comb begin
    rxState_next = rxState_reg;
    case (rxState_reg)
      uwr_pkg::RX_IDLE: if (fallEdge) rxState_next = uwr_pkg::RX_START;
      uwr_pkg::RX_START: begin
        if (rxDecide && rxVote) rxState_next = uwr_pkg::RX_IDLE;
        else if (rxBitEnd) rxState_next = uwr_pkg::RX_DATA;
      end
      uwr_pkg::RX_DATA: begin
        if (rxBitEnd && rxBit_reg == 4'h8) begin
          rxState_next = ctrl_reg.nineBit ? uwr_pkg::RX_NINTH : uwr_pkg::RX_STOP;
        end
      end
      uwr_pkg::RX_NINTH: if (rxBitEnd) rxState_next = uwr_pkg::RX_STOP;
      uwr_pkg::RX_STOP: if (rxEnd) rxState_next = uwr_pkg::RX_IDLE;
      default: rxState_next = uwr_pkg::RX_IDLE;
    endcase
  end

  // Sub-slot count, resynchronised on a falling edge that follows three high samples
  always_ff @(posedge sys_clk) begin
    if (!resetn || rxAbort) begin
      rxState_reg <= uwr_pkg::RX_IDLE;
      rxSub_reg <= 4'h0;
      rxBit_reg <= 4'h0;
      rxVote_reg <= 2'h3;
      rxEdge_reg <= 3'h0;
    end else begin
      rxState_reg <= rxState_next;
      if (tick16) begin
        rxEdge_reg <= {rxEdge_reg[1:0], rxIn};
        rxSub_reg <= fallEdge ? 4'h0 : rxSubInc;
        if (rxSubInc == uwr_pkg::RT8 || rxSubInc == uwr_pkg::RT9) rxVote_reg <= {rxVote_reg[0], rxIn};
        if (rxState_reg == uwr_pkg::RX_IDLE) rxBit_reg <= 4'h0;
        else if (rxDecide && rxState_reg == uwr_pkg::RX_DATA) rxBit_reg <= rxBit_reg + 4'h1;
      end
    end
  end

  // Shift in data bits LSB first and capture the ninth
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxShift_reg <= 8'h00;
      rxNinthVal_reg <= 1'b0;
    end else if (rxDecide) begin
      if (rxState_reg == uwr_pkg::RX_DATA) rxShift_reg <= {rxVote, rxShift_reg[7:1]};
      if (rxState_reg == uwr_pkg::RX_NINTH) rxNinthVal_reg <= rxVote;
      if (rxState_reg == uwr_pkg::RX_DATA && !ctrl_reg.nineBit) rxNinthVal_reg <= 1'b0;
    end
  end

  // Receive buffer and received ninth bit
  always_ff @(posedge sys_clk) begin
    if (!resetn || engineClr) begin
      rxBuf_reg <= uwr_pkg::CHAR_RESET;
      rxNinthBit_reg <= 1'b0;
    end else if (rxLoad) begin
      rxBuf_reg <= rxShift_reg;
      rxNinthBit_reg <= rxNinthVal_reg;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  wire logic [4:0] clrMask = wrClr ? regWrData[4:0] : 5'h00;
  wire logic [4:0] setMask = {txDone,
                              rxLoad,
                              rxAccept && flags_reg.rxFullFlag,
                              rxAccept && !rxVote,
                              rxAccept && ctrl_reg.nineBit && ctrl_reg.parityCheckOn &&
                              (rxNinthVal_reg != rxExpParity)};
  // Set wins over a same-cycle clear
  assign flags_next = engineClr ? 5'h00 : (setMask | (flags_reg & ~clrMask));

  // Wake-up flag from a low receive level while enabled
  logic wakeSeenFlag_reg;
  wire logic wakeSet = sleepWakeOn_reg && ctrl_reg.rxSideOn && ctrl_reg.unitOn && !rxIn;
  wire logic wakeClr = wrWake && regWrData[uwr_pkg::WAKE_CLR_BIT];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flags_reg <= 5'h00;
      wakeSeenFlag_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      wakeSeenFlag_reg <= wakeSet || (wakeSeenFlag_reg && !wakeClr && !engineClr);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  wire logic [31:0] statWord = {25'h0000000, rxNinthBit_reg, txNinthBit_reg, flags_reg};
  wire logic [31:0] rdMux =
    (regAddr == uwr_pkg::BAUD_OFS) ? {19'h00000, baudDivisor_reg} :
    (regAddr == uwr_pkg::CTRL_OFS) ? {24'h000000, ctrl_reg} :
    (regAddr == uwr_pkg::IRQF_OFS) ? {29'h00000000, irqCtrl_reg} :
    (regAddr == uwr_pkg::STAT_OFS) ? statWord :
    (regAddr == uwr_pkg::CHAR_OFS) ? {24'h000000, rxBuf_reg} :
    (regAddr == uwr_pkg::WAKE_OFS) ? {30'h00000000, wakeSeenFlag_reg, sleepWakeOn_reg} :
    (regAddr == uwr_pkg::ROUTE_OFS) ? {18'h00000, pinRoute_reg} : 32'h00000000;

  // Read data, interrupt, wake and line outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      regRdData <= 32'h00000000;
      irqOut <= 1'b0;
      wakeOut <= 1'b0;
      txLine_reg <= 1'b1;
    end else begin
      regRdData <= regRdEn ? rdMux : 32'h00000000;
      irqOut <= (flags_next.txEmptyFlag && irqCtrl_reg.txIrqGate) ||
                (flags_next.rxFullFlag && irqCtrl_reg.rxIrqGate);
      wakeOut <= wakeSet || (wakeSeenFlag_reg && !wakeClr && !engineClr);
      txLine_reg <= txLine_next;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Selected pair drives the transmit line on its A pin, or B when swapped
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pair
      wire logic pairHit = (pinPairSelect == 2'(p));
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          pinAOut[p] <= 1'b1;
          pinBOut[p] <= 1'b1;
          pinAOe[p] <= 1'b0;
          pinBOe[p] <= 1'b0;
        end else begin
          pinAOut[p] <= txLine_reg;
          pinBOut[p] <= txLine_reg;
          pinAOe[p] <= pairHit && !pinSwap;
          pinBOe[p] <= pairHit && pinSwap;
        end
      end
    end
  endgenerate
endmodule : uwr_top

// [dv/uwr_props.sv]
// Port assertions for the serial transceiver top
module uwr_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic [3:0] pinAOe,
  input wire logic [3:0] pinBOe,
  input wire logic irqOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Read port and reserved bits
  rd_idle_zero_a: assert property (!regRdEn |=> regRdData == 32'h0)
    else $error("read data outside read");
  baud_rsvd_a: assert property (regRdEn && regAddr == 8'h00 |=> regRdData[31:13] == 19'h0)
    else $error("baud reserved bits set");
  stat_rsvd_a: assert property (regRdEn && regAddr == 8'h0C |=> regRdData[31:7] == 25'h0)
    else $error("status reserved bits set");
  clr_reads_zero_a: assert property (regRdEn && regAddr == 8'h14 |=> regRdData == 32'h0)
    else $error("clear register read nonzero");
  wake_rsvd_a: assert property (regRdEn && regAddr == 8'h18 |=> regRdData[31:2] == 30'h0)
    else $error("wake clear bit read nonzero");
  route_rsvd_a: assert property (regRdEn && regAddr == 8'h40 |=> regRdData[31:14] == 18'h0)
    else $error("route reserved bits set");
  // Pin drive and unit clear
  pin_drive_a: assert property ($onehot0({pinAOe, pinBOe}))
    else $error("more than one pin driven");
  unit_off_a: assert property (regWrEn && regAddr == 8'h04 && !regWrData[7] |=> ##[1:2] !irqOut)
    else $error("irq kept after unit off");
endmodule : uwr_props
bind uwr_top uwr_props u_props (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .pinAOe(pinAOe), .pinBOe(pinBOe), .irqOut(irqOut));

// [dv/uwr_remote.sv]
// Remote transmitter model that drives the receive pin
module uwr_remote (
  input wire logic sys_clk,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line rests high between frames
  initial rxLine = 1'b1;
  // Frame goes out LSB first, one bit per bitCycles clocks
  task automatic send(input logic [11:0] frame, input int nBits, input int bitCycles);
    for (int i = 0; i < nBits; i++) begin
      @(posedge sys_clk);
      rxLine <= frame[i];
      repeat (bitCycles - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rxLine <= 1'b1;
  endtask : send
endmodule : uwr_remote

// [dv/uwr_top_tb_top.sv]
// Self-checking bench for the serial transceiver top
module uwr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic [3:0] pinAOut, pinAOe, pinBOut, pinBOe;
  logic irqOut, wakeOut, remLine;
  logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
  int fails = 0;
  int totalChecks = 0;
  // Clock, far-side model and device
  always #5 sys_clk = ~sys_clk;
  uwr_remote u_rem (.sys_clk(sys_clk), .rxLine(remLine));
  uwr_top #(.INSTANCE(0)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .pinAIn({2'h3, remLine, 1'b1}),
    .pinBIn({3'h7, remLine}),
    .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOut(pinBOut), .pinBOe(pinBOe), .irqOut(irqOut), .wakeOut(wakeOut));
  // Verdict and comparison helpers
  task automatic final_report();
    if (fails == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic tmo();
    fails++;
    final_report();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rd
  // Route setting against pin drive enables
  task automatic pin_case(input logic [31:0] route, input logic [7:0] exp);
    wr(8'h40, route);
    repeat (3) @(posedge sys_clk);
    chk({pinAOe, pinBOe}, exp);
  endtask : pin_case
  // One character out: line bits mid-bit, then the empty irq
  task automatic tx_case(input logic [7:0] ctl, input logic [7:0] d, input logic ninth);
    logic [11:0] f;
    int n;
    int k;
    f = ctl[2] ? {2'b11, ninth, d, 1'b0} : {3'b111, d, 1'b0};
    n = 10 + ctl[2] + ctl[3];
    wr(8'h04, ctl);
    wr(8'h10, d);
    for (k = 0; k < 200 && pinAOut[0]; k++) @(posedge sys_clk);
    if (k == 200) tmo();
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      chk({pinAOut[0], pinBOut[0]}, {2{f[i]}});
      if (i < n - 1) repeat (BIT) @(posedge sys_clk);
    end
    for (k = 0; k < 40 && !irqOut; k++) @(posedge sys_clk);
    if (k == 40) tmo();
    chk(k > 8 && k < 20, 1'b1);
    wr(8'h14, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(irqOut, 1'b0);
  endtask : tx_case
  // One frame in: irq, status, data, then optional clear
  task automatic rx_case(input logic nine, input logic [8:0] d, input logic stp, input logic [7:0] st,
    input logic [7:0] ed, input logic clr);
    logic [11:0] f;
    int k;
    f = nine ? {1'b1, stp, d, 1'b0} : {2'b11, stp, d[7:0], 1'b0};
    u_rem.send(f, 10 + nine, BIT);
    for (k = 0; k < 20 && !irqOut; k++) @(posedge sys_clk);
    if (k == 20 && st[3]) tmo();
    chk(irqOut, st[3]);
    rd(8'h0C, st);
    if (st[3]) rd(8'h10, ed);
    if (clr) wr(8'h14, 32'h0F);
  endtask : rx_case
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ofs[i], ofs[i] == 8'h10 ? 32'hFF : 32'h0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h20);
    wr(8'h04, 32'h06);
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'h20);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h1FFF);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h3FFF);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h7);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'hE0);
    repeat (60) @(posedge sys_clk);
    pin_case(32'h0, 8'h10);
    pin_case(32'h1, 8'h01);
    pin_case(32'h20, 8'h20);
    wr(8'h40, 32'h0);
    tx_case(8'hE0, 8'hA5, 1'b1);
    tx_case(8'hE8, 8'h5A, 1'b1);
    tx_case(8'hE6, 8'h81, 1'b0);
    tx_case(8'hE7, 8'h81, 1'b1);
    wr(8'h04, 32'hE4);
    wr(8'h0C, 32'h20);
    tx_case(8'hE4, 8'h00, 1'b1);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'hE0);
    wr(8'h18, 32'h1);
    rx_case(1'b0, 9'h03C, 1'b1, 8'h08, 8'h3C, 1'b1);
    chk(wakeOut, 1'b1);
    wr(8'h18, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk(wakeOut, 1'b0);
    rx_case(1'b0, 9'h0A5, 1'b0, 8'h0A, 8'hA5, 1'b1);
    wr(8'h04, 32'hE6);
    rx_case(1'b1, 9'h107, 1'b1, 8'h48, 8'h07, 1'b1);
    rx_case(1'b1, 9'h007, 1'b1, 8'h09, 8'h07, 1'b1);
    wr(8'h04, 32'hE7);
    rx_case(1'b1, 9'h107, 1'b1, 8'h49, 8'h07, 1'b1);
    wr(8'h04, 32'hF4);
    rx_case(1'b1, 9'h033, 1'b1, 8'h40, 8'h00, 1'b1);
    rx_case(1'b1, 9'h1AB, 1'b1, 8'h48, 8'hAB, 1'b1);
    wr(8'h04, 32'hE0);
    wr(8'h40, 32'h21);
    rx_case(1'b0, 9'h05A, 1'b1, 8'h08, 8'h5A, 1'b1);
    wr(8'h40, 32'h0);
    rx_case(1'b0, 9'h011, 1'b1, 8'h08, 8'h11, 1'b0);
    rx_case(1'b0, 9'h022, 1'b1, 8'h0C, 8'h11, 1'b0);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge sys_clk);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'hFF);
    final_report();
  end
endmodule : uwr_top_tb_top
